// ===== include/iqcor_map.svh
// Register map, field positions, reset values and arithmetic constants of the I/Q corrector.
`ifndef IQCOR_MAP_SVH
`define IQCOR_MAP_SVH

// ==========================================================================
// Register offsets
// ==========================================================================
`define IQCOR_DATAPATH_CONTROL_ADDR 7'h1B
`define IQCOR_I_PHASE_LO_ADDR 7'h38
`define IQCOR_I_PHASE_HI_ADDR 7'h39
`define IQCOR_Q_PHASE_LO_ADDR 7'h3A
`define IQCOR_Q_PHASE_HI_ADDR 7'h3B
`define IQCOR_I_OFFSET_LO_ADDR 7'h3C
`define IQCOR_I_OFFSET_HI_ADDR 7'h3D
`define IQCOR_Q_OFFSET_LO_ADDR 7'h3E
`define IQCOR_Q_OFFSET_HI_ADDR 7'h3F

// ==========================================================================
// Fields and reset values
// ==========================================================================
`define IQCOR_SINC_BYPASS_BIT 6
`define IQCOR_DATAPATH_CONTROL_RST 8'h40
`define IQCOR_PHASE_RST 10'h000
`define IQCOR_OFFSET_RST 16'h0000

// ==========================================================================
// Arithmetic
// ==========================================================================
// Phase coefficient: a full-scale code of 511 gives about 0.0305 rad (1.75 deg).
// Scale is Q2.16 of the partner sample: 0.0305 * 65536 / 511 is about 4.
`define IQCOR_PHASE_SHIFT 14
// Inverse sinc taps, Q.10, sum 708/1024 (about -3.2 dB), symmetric.
// Fitted to the inverse of the hold droop at 0, 0.1, 0.2, 0.3 and 0.4 of the
// clock, so the combined ripple stays within a few hundredths of a dB.
`define IQCOR_TAP0 12'sh001
`define IQCOR_TAP1 12'shFFB
`define IQCOR_TAP2 12'sh012
`define IQCOR_TAP3 12'shFBB
`define IQCOR_TAP4 12'sh332
`define IQCOR_FIR_SHIFT 10

`endif

// ===== include/iqcor_pkg.sv
// Types shared by the I/Q corrector.
package iqcor_pkg;
	// Signed sample word as carried on the stream.
	typedef logic signed [15:0] iqcor_sample_t;
	// Configuration bus access states.
	typedef enum logic [0:0] {IQCOR_IDLE, IQCOR_READ} iqcor_state_t;
endpackage : iqcor_pkg

// ===== src/iqcor_corrector.sv
// I/Q phase trim, DC offset and inverse sinc correction stage.
`timescale 1ns/1ps
`include "iqcor_map.svh"
// ==========================================================================
// Notes on behaviour
// (R1) I trim 10 bits, negative widens angle.
// (R2) Positive I trim narrows inter-channel angle.
// (R3) Q trim separate, symmetric to I.
// (R4) Trim is linear across 1024 codes.
// (R5) Independent 16-bit offset added per channel.
// (R6) Samples twos complement, zero is midscale.
// (R7) Software keeps offset plus signal in range.
// (R8) Inverse sinc is nine-tap FIR.
// (R9) Filter bypassed at reset, bit 6 clears.
// (R10) Taps flatten response to 0.4 fclk.
// (R11) Filter carries about 3.2 dB loss.
// (R12) Sums saturate, never wrap.
// (R13) Settings change only between whole samples.
// ==========================================================================
module iqcor_corrector #(
	parameter int SAMPLE_WIDTH = 16
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic signed [SAMPLE_WIDTH-1:0] i_sample_i,
	input wire logic signed [SAMPLE_WIDTH-1:0] q_sample_i,
	input wire logic sample_valid_i,
	input wire logic cfg_write_i,
	input wire logic cfg_read_i,
	input wire logic [6:0] cfg_addr_i,
	input wire logic [7:0] cfg_wdata_i,
	output logic [7:0] cfg_rdata_o,
	output logic cfg_rvalid_o,
	output logic signed [SAMPLE_WIDTH-1:0] i_sample_o,
	output logic signed [SAMPLE_WIDTH-1:0] q_sample_o,
	output logic sample_valid_o
);
	localparam int W = SAMPLE_WIDTH;
	localparam int AW = W + 14;

	// ======================================================================
	// Helpers
	// ======================================================================
	// Clamp a wide signed value into the sample range rather than wrapping.
	function automatic logic signed [W-1:0] sat(input logic signed [AW-1:0] v);
		logic signed [AW-1:0] hi;
		logic signed [AW-1:0] lo;
		hi = AW'((1 <<< (W - 1)) - 1);
		lo = -hi - AW'(1);
		if (v > hi) begin
			sat = hi[W-1:0]; // R12
		end else if (v < lo) begin
			sat = lo[W-1:0]; // R12
		end else begin
			sat = v[W-1:0];
		end
	endfunction : sat

	// Return the symmetric tap for position k of the nine.
	function automatic logic signed [11:0] tap(input int k);
		int m;
		m = (k > 4) ? 8 - k : k;
		case (m)
			0: tap = `IQCOR_TAP0;
			1: tap = `IQCOR_TAP1;
			2: tap = `IQCOR_TAP2;
			3: tap = `IQCOR_TAP3;
			default: tap = `IQCOR_TAP4;
		endcase
	endfunction : tap

	// ======================================================================
	// Configuration registers
	// ======================================================================
	logic [7:0] datapath_control; // Bit 6 bypasses the inverse sinc.
	logic [9:0] i_channel_phase_trim; // Signed trim code for I.
	logic [9:0] q_channel_phase_trim; // Signed trim code for Q.
	logic [15:0] i_channel_dc_offset; // Offset added to I.
	logic [15:0] q_channel_dc_offset; // Offset added to Q.
	logic [7:0] next_datapath_control;
	logic [9:0] next_i_phase;
	logic [9:0] next_q_phase;
	logic [15:0] next_i_offset;
	logic [15:0] next_q_offset;
	logic [7:0] next_rdata;
	iqcor_pkg::iqcor_state_t state;
	iqcor_pkg::iqcor_state_t next_state;

	// Decode byte writes and build read data for the addressed byte.
	always_comb begin
		next_datapath_control = datapath_control;
		next_i_phase = i_channel_phase_trim;
		next_q_phase = q_channel_phase_trim;
		next_i_offset = i_channel_dc_offset;
		next_q_offset = q_channel_dc_offset;
		next_rdata = 8'h00;
		next_state = cfg_read_i ? iqcor_pkg::IQCOR_READ : iqcor_pkg::IQCOR_IDLE;
		if (cfg_write_i) begin
			case (cfg_addr_i)
				`IQCOR_DATAPATH_CONTROL_ADDR: next_datapath_control = cfg_wdata_i; // R9
				`IQCOR_I_PHASE_LO_ADDR: next_i_phase[7:0] = cfg_wdata_i; // R1
				`IQCOR_I_PHASE_HI_ADDR: next_i_phase[9:8] = cfg_wdata_i[1:0]; // R1
				`IQCOR_Q_PHASE_LO_ADDR: next_q_phase[7:0] = cfg_wdata_i; // R3
				`IQCOR_Q_PHASE_HI_ADDR: next_q_phase[9:8] = cfg_wdata_i[1:0]; // R3
				`IQCOR_I_OFFSET_LO_ADDR: next_i_offset[7:0] = cfg_wdata_i; // R5
				`IQCOR_I_OFFSET_HI_ADDR: next_i_offset[15:8] = cfg_wdata_i; // R5
				`IQCOR_Q_OFFSET_LO_ADDR: next_q_offset[7:0] = cfg_wdata_i; // R5
				`IQCOR_Q_OFFSET_HI_ADDR: next_q_offset[15:8] = cfg_wdata_i; // R5
				default: begin
				end
			endcase
		end
		// Unmapped addresses read as zero.
		case (cfg_addr_i)
			`IQCOR_DATAPATH_CONTROL_ADDR: next_rdata = datapath_control;
			`IQCOR_I_PHASE_LO_ADDR: next_rdata = i_channel_phase_trim[7:0];
			`IQCOR_I_PHASE_HI_ADDR: next_rdata = {6'h00, i_channel_phase_trim[9:8]};
			`IQCOR_Q_PHASE_LO_ADDR: next_rdata = q_channel_phase_trim[7:0];
			`IQCOR_Q_PHASE_HI_ADDR: next_rdata = {6'h00, q_channel_phase_trim[9:8]};
			`IQCOR_I_OFFSET_LO_ADDR: next_rdata = i_channel_dc_offset[7:0];
			`IQCOR_I_OFFSET_HI_ADDR: next_rdata = i_channel_dc_offset[15:8];
			`IQCOR_Q_OFFSET_LO_ADDR: next_rdata = q_channel_dc_offset[7:0];
			`IQCOR_Q_OFFSET_HI_ADDR: next_rdata = q_channel_dc_offset[15:8];
			default: next_rdata = 8'h00;
		endcase
		if (!cfg_read_i) begin
			next_rdata = 8'h00;
		end
	end

	// Register the configuration; the filter starts bypassed.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			datapath_control <= `IQCOR_DATAPATH_CONTROL_RST; // R9
			i_channel_phase_trim <= `IQCOR_PHASE_RST;
			q_channel_phase_trim <= `IQCOR_PHASE_RST;
			i_channel_dc_offset <= `IQCOR_OFFSET_RST;
			q_channel_dc_offset <= `IQCOR_OFFSET_RST;
			cfg_rdata_o <= 8'h00;
			cfg_rvalid_o <= 1'b0;
			state <= iqcor_pkg::IQCOR_IDLE;
		end else begin
			datapath_control <= next_datapath_control;
			i_channel_phase_trim <= next_i_phase;
			q_channel_phase_trim <= next_q_phase;
			i_channel_dc_offset <= next_i_offset;
			q_channel_dc_offset <= next_q_offset;
			cfg_rdata_o <= next_rdata;
			cfg_rvalid_o <= (next_state == iqcor_pkg::IQCOR_READ);
			state <= next_state;
		end
	end

	// ======================================================================
	// Settings snapshot
	// ======================================================================
	// Settings are latched only when no write is in progress and no low byte
	// awaits its high byte, so a sample never sees half of a pair written low byte first. // R13
	logic [9:0] act_i_phase;
	logic [9:0] act_q_phase;
	logic [15:0] act_i_offset;
	logic [15:0] act_q_offset;
	logic act_bypass;
	logic half_pend; // A low byte is written and its high byte is still due.
	logic next_half_pend;

	// A low-byte write arms the hold and any high-byte write releases it.
	// Limitation: a lone low-byte write holds every setting until some high
	// byte follows, so software must always write both bytes of a pair.
	always_comb begin
		next_half_pend = half_pend;
		if (cfg_write_i) begin
			case (cfg_addr_i)
				`IQCOR_I_PHASE_LO_ADDR, `IQCOR_Q_PHASE_LO_ADDR: begin
					next_half_pend = 1'b1; // R13
				end
				`IQCOR_I_OFFSET_LO_ADDR, `IQCOR_Q_OFFSET_LO_ADDR: begin
					next_half_pend = 1'b1; // R13
				end
				`IQCOR_I_PHASE_HI_ADDR, `IQCOR_Q_PHASE_HI_ADDR: begin
					next_half_pend = 1'b0;
				end
				`IQCOR_I_OFFSET_HI_ADDR, `IQCOR_Q_OFFSET_HI_ADDR: begin
					next_half_pend = 1'b0;
				end
				default: begin
					// Other addresses leave the hold as it stands.
				end
			endcase
		end
	end

	// Register the hold and take a snapshot only between complete updates.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			half_pend <= 1'b0;
			act_i_phase <= `IQCOR_PHASE_RST;
			act_q_phase <= `IQCOR_PHASE_RST;
			act_i_offset <= `IQCOR_OFFSET_RST;
			act_q_offset <= `IQCOR_OFFSET_RST;
			act_bypass <= 1'b1;
		end else begin
			half_pend <= next_half_pend;
			if (!cfg_write_i && !half_pend) begin
				// Apply a settled set of registers; a write in progress is skipped. // R13
				act_i_phase <= i_channel_phase_trim;
				act_q_phase <= q_channel_phase_trim;
				act_i_offset <= i_channel_dc_offset;
				act_q_offset <= q_channel_dc_offset;
				act_bypass <= datapath_control[`IQCOR_SINC_BYPASS_BIT]; // R9
			end
		end
	end

	// ======================================================================
	// Stage 1: phase trim and DC offset
	// ======================================================================
	logic signed [W-1:0] s1_i;
	logic signed [W-1:0] s1_q;
	logic s1_v;
	logic signed [W-1:0] next_s1_i;
	logic signed [W-1:0] next_s1_q;

	// Each channel takes a small linear fraction of the other channel,
	// which tilts the angle between them; a negative code widens it. // R4
	always_comb begin
		logic signed [AW-1:0] prod_i;
		logic signed [AW-1:0] prod_q;
		logic signed [AW-1:0] sum_i;
		logic signed [AW-1:0] sum_q;
		prod_i = AW'(q_sample_i) * AW'($signed(act_i_phase)); // R1 R2
		prod_q = AW'(i_sample_i) * AW'($signed(act_q_phase)); // R3
		// Offset is a twos complement shift about midscale zero. // R6
		sum_i = AW'(i_sample_i) + (prod_i >>> `IQCOR_PHASE_SHIFT)
			+ AW'($signed(act_i_offset)); // R5
		sum_q = AW'(q_sample_i) + (prod_q >>> `IQCOR_PHASE_SHIFT)
			+ AW'($signed(act_q_offset)); // R5
		next_s1_i = sat(sum_i); // R12 R7
		next_s1_q = sat(sum_q); // R12
	end

	// Stage 1 register.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_i <= '0;
			s1_q <= '0;
			s1_v <= 1'b0;
		end else begin
			s1_i <= next_s1_i;
			s1_q <= next_s1_q;
			s1_v <= sample_valid_i;
		end
	end

	// ======================================================================
	// Stage 2: nine-tap inverse sinc
	// ======================================================================
	// The delay line runs every converter clock, as the filter does. // R8
	logic signed [W-1:0] dl_i [0:8];
	logic signed [W-1:0] dl_q [0:8];
	logic signed [W-1:0] next_out_i;
	logic signed [W-1:0] next_out_q;

	// Form the filtered output or pass the delayed sample when bypassed.
	always_comb begin
		logic signed [AW-1:0] acc_i;
		logic signed [AW-1:0] acc_q;
		acc_i = '0;
		acc_q = '0;
		for (int k = 0; k < 9; k++) begin
			acc_i = acc_i + AW'(dl_i[k]) * AW'(tap(k)); // R8 R10
			acc_q = acc_q + AW'(dl_q[k]) * AW'(tap(k)); // R8 R10
		end
		// Taps sum below unity, giving the headroom for peaking. // R11
		if (act_bypass) begin
			next_out_i = dl_i[4];
			next_out_q = dl_q[4];
		end else begin
			next_out_i = sat(acc_i >>> `IQCOR_FIR_SHIFT); // R12
			next_out_q = sat(acc_q >>> `IQCOR_FIR_SHIFT); // R12
		end
	end

	// Shift the delay line and register outputs; valid tracks the centre tap
	// so bypassed and filtered paths share one latency. // R13
	logic [4:0] vdl;
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int k = 0; k < 9; k++) begin
				dl_i[k] <= '0;
				dl_q[k] <= '0;
			end
			vdl <= 5'h00;
			i_sample_o <= '0;
			q_sample_o <= '0;
			sample_valid_o <= 1'b0;
		end else begin
			dl_i[0] <= s1_i;
			dl_q[0] <= s1_q;
			for (int k = 1; k < 9; k++) begin
				dl_i[k] <= dl_i[k-1];
				dl_q[k] <= dl_q[k-1];
			end
			vdl <= {vdl[3:0], s1_v};
			i_sample_o <= next_out_i;
			q_sample_o <= next_out_q;
			sample_valid_o <= vdl[4];
		end
	end
endmodule : iqcor_corrector

// ===== testbench/iqcor_asserts.sv
// Concurrent checks on the corrector's configuration and stream ports.
`timescale 1ns/1ps
`include "iqcor_map.svh"
// ==========================================================================
// Checker
// ==========================================================================
module iqcor_asserts #(
	parameter int SAMPLE_WIDTH = 16
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic signed [SAMPLE_WIDTH-1:0] i_sample_i,
	input wire logic signed [SAMPLE_WIDTH-1:0] q_sample_i,
	input wire logic sample_valid_i,
	input wire logic cfg_write_i,
	input wire logic cfg_read_i,
	input wire logic [6:0] cfg_addr_i,
	input wire logic [7:0] cfg_wdata_i,
	input wire logic [7:0] cfg_rdata_o,
	input wire logic cfg_rvalid_o,
	input wire logic signed [SAMPLE_WIDTH-1:0] i_sample_o,
	input wire logic signed [SAMPLE_WIDTH-1:0] q_sample_o,
	input wire logic sample_valid_o
);
	logic [3:0] cnt; // Cycles since reset; keeps $past clear of reset history.
	logic [3:0] next_cnt;
	logic zs; // High while no write has moved a setting off its reset value.
	logic next_zs;
	// Any write of a non-reset byte clears zs; conservative, never sets it again.
	always_comb begin
		next_cnt = (cnt == 4'hF) ? cnt : cnt + 4'h1;
		next_zs = zs && !(cfg_write_i && cfg_wdata_i != ((cfg_addr_i ==
			`IQCOR_DATAPATH_CONTROL_ADDR) ? `IQCOR_DATAPATH_CONTROL_RST : 8'h00));
	end
	// Helper registers only.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 4'h0;
			zs <= 1'b1;
		end else begin
			cnt <= next_cnt;
			zs <= next_zs;
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	property p_rd_ans; cfg_read_i |=> cfg_rvalid_o; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_rd_only; cfg_rvalid_o |-> $past(cfg_read_i); endproperty
	a_rd_only: assert property (p_rd_only) else $error("answer without read");
	property p_rd_zero; !cfg_rvalid_o |-> cfg_rdata_o == 8'h00; endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read data not idle");
	property p_rd_ctl; cfg_read_i && zs && cfg_addr_i == `IQCOR_DATAPATH_CONTROL_ADDR
		|=> cfg_rdata_o == `IQCOR_DATAPATH_CONTROL_RST; endproperty
	a_rd_ctl: assert property (p_rd_ctl) else $error("control reset value");
	property p_rd_unm; cfg_read_i && cfg_addr_i > 7'h3F |=> cfg_rdata_o == 8'h00; endproperty
	a_rd_unm: assert property (p_rd_unm) else $error("unmapped read not zero");
	property p_vld_on; sample_valid_i |-> ##7 sample_valid_o; endproperty
	a_vld_on: assert property (p_vld_on) else $error("sample lost");
	property p_vld_pst; cnt == 4'hF |-> sample_valid_o == $past(sample_valid_i, 7); endproperty
	a_vld_pst: assert property (p_vld_pst) else $error("valid misaligned");
	property p_id_i; zs && cnt == 4'hF |-> i_sample_o == $past(i_sample_i, 7); endproperty
	a_id_i: assert property (p_id_i) else $error("I altered at reset settings");
	property p_id_q; zs && cnt == 4'hF |-> q_sample_o == $past(q_sample_i, 7); endproperty
	a_id_q: assert property (p_id_q) else $error("Q altered at reset settings");
	c_rd: cover property (cfg_read_i ##1 cfg_rvalid_o);
	c_str: cover property (sample_valid_o [*4]);
	c_flt: cover property (cfg_write_i && cfg_addr_i == `IQCOR_DATAPATH_CONTROL_ADDR
		&& !cfg_wdata_i[`IQCOR_SINC_BYPASS_BIT]);
endmodule : iqcor_asserts
bind iqcor_corrector iqcor_asserts #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) u_chk (.*);

// ===== testbench/iqcor_src_model.sv
// Upstream datapath model that hands the corrector one sample pair per load.
`timescale 1ns/1ps
// ==========================================================================
// Source model
// ==========================================================================
module iqcor_src_model (
	input wire logic ref_clk_i,
	input wire logic load_i,
	input wire logic signed [15:0] i_val_i,
	input wire logic signed [15:0] q_val_i,
	output logic signed [15:0] i_sample_o,
	output logic signed [15:0] q_sample_o,
	output logic sample_valid_o
);
	logic pend = 1'b0; // A pair waits to be driven.
	logic signed [15:0] pi = 16'sh0000;
	logic signed [15:0] pq = 16'sh0000;
	initial begin
		i_sample_o = 16'sh0000;
		q_sample_o = 16'sh0000;
		sample_valid_o = 1'b0;
	end
	// Requests are taken on the rising edge so bench and model never race.
	always @(posedge ref_clk_i) begin
		pend <= load_i;
		pi <= i_val_i;
		pq <= q_val_i;
	end
	// Driven on the falling edge; idle cycles show the inverse so stale data never passes.
	always @(negedge ref_clk_i) begin
		sample_valid_o <= pend;
		i_sample_o <= pend ? pi : ~i_sample_o;
		q_sample_o <= pend ? pq : ~q_sample_o;
	end
endmodule : iqcor_src_model

// ===== testbench/iqcor_corrector_tb.sv
// Self-checking bench for the I/Q corrector fed by the source model.
`timescale 1ns/1ps
`include "iqcor_map.svh"
// ==========================================================================
// Bench
// ==========================================================================
module iqcor_corrector_tb;
	localparam int FSUM = 2 * (`IQCOR_TAP0 + `IQCOR_TAP1 + `IQCOR_TAP2 + `IQCOR_TAP3)
		+ `IQCOR_TAP4; // DC gain of the filter, out of 1024.
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cfg_write_i = 1'b0;
	logic cfg_read_i = 1'b0;
	logic [6:0] cfg_addr_i = 7'h00;
	logic [7:0] cfg_wdata_i = 8'h00;
	logic [7:0] cfg_rdata_o;
	logic cfg_rvalid_o, sample_valid_i, sample_valid_o;
	logic signed [15:0] i_sample_i, q_sample_i, i_sample_o, q_sample_o;
	logic ld = 1'b0; // Asks the source model for one pair.
	logic signed [15:0] iv = 16'sh0000, qv = 16'sh0000, ra, rb;
	logic signed [15:0] ioff = 16'sh0000, qoff = 16'sh0000; // Shadow of the settings.
	logic signed [9:0] itr = 10'sh000, qtr = 10'sh000;
	logic signed [9:0] tabl [4] = '{10'sh200, 10'sh1FF, 10'sh001, 10'sh000};
	logic flt = 1'b0; // Filter in the path.
	logic [32:0] sq [$]; // Check flag, expected I, expected Q.
	logic [7:0] rq [$];
	logic [32:0] e;
	int num_errors = 0;
	int cmp_count = 0;
	iqcor_src_model src (.ref_clk_i(ref_clk_i), .load_i(ld), .i_val_i(iv), .q_val_i(qv),
		.i_sample_o(i_sample_i), .q_sample_o(q_sample_i), .sample_valid_o(sample_valid_i));
	iqcor_corrector #(.SAMPLE_WIDTH(16)) uut (.*);
	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// Clamp to the sample range instead of wrapping.
	function automatic logic signed [15:0] sat(input logic signed [31:0] s);
		return (s > 32'sh00007FFF) ? 16'sh7FFF : (s < -32'sh00008000) ? 16'sh8000 : s[15:0];
	endfunction : sat
	function automatic logic signed [15:0] fx(input logic signed [15:0] a, b, o,
		input logic signed [9:0] t);
		logic signed [31:0] s;
		s = sat(a + ((b * t) >>> `IQCOR_PHASE_SHIFT) + o);
		return flt ? sat((s * FSUM) >>> `IQCOR_FIR_SHIFT) : s[15:0];
	endfunction : fx
	task automatic chk(input logic [31:0] x, g);
		cmp_count++;
		if (g !== x) begin
			num_errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, x, g);
		end
	endtask : chk
	task automatic end_sim();
		if (rq.size() != 0) num_errors++;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		cfg_write_i = 1'b1;
		cfg_addr_i = a;
		cfg_wdata_i = d;
		@(negedge ref_clk_i);
		cfg_write_i = 1'b0;
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] x);
		@(negedge ref_clk_i);
		cfg_read_i = 1'b1;
		cfg_addr_i = a;
		rq.push_back(x);
		@(negedge ref_clk_i);
		cfg_read_i = 1'b0;
	endtask : rd
	task automatic set16(input logic [6:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 7'h01, v[15:8]);
	endtask : set16
	task automatic send(input logic signed [15:0] a, b, input logic c);
		@(negedge ref_clk_i);
		ld = 1'b1;
		iv = a;
		qv = b;
		sq.push_back({c, fx(a, b, ioff, itr), fx(b, a, qoff, qtr)});
	endtask : send
	// Stop the stream and wait, bounded, until every pair has come out.
	task automatic idle();
		@(negedge ref_clk_i);
		ld = 1'b0;
		for (int k = 0; k < 20 && sq.size() != 0; k++) @(negedge ref_clk_i);
		if (sq.size() != 0) begin
			num_errors++;
			end_sim();
		end
	endtask : idle
	// Random pairs a quarter of full scale, so offsets never push them over.
	task automatic burst(input int n);
		for (int k = 0; k < n; k++) begin
			ra = 16'($urandom);
			rb = 16'($urandom);
			send(ra >>> 2, rb >>> 2, 1'b1);
		end
		idle();
	endtask : burst
	// Results are compared as they appear, oldest note first.
	always @(negedge ref_clk_i) begin
		if (sample_valid_o === 1'b1 && sq.size() == 0) begin
			chk(32'h00000000, 32'h00000001);
		end else if (sample_valid_o === 1'b1) begin
			e = sq.pop_front();
			if (e[32] !== 1'b0) chk(e[31:0], {i_sample_o, q_sample_o});
		end
		if (cfg_rvalid_o === 1'b1 && rq.size() == 0) begin
			chk(32'h00000000, 32'h00000001);
		end else if (cfg_rvalid_o === 1'b1) begin
			chk({24'h000000, rq.pop_front()}, {24'h000000, cfg_rdata_o});
		end
	end
	initial begin
		void'($urandom(32'hA537));
		repeat (4) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rst_i = 1'b0;
		burst(16);
		rd(`IQCOR_DATAPATH_CONTROL_ADDR, `IQCOR_DATAPATH_CONTROL_RST);
		rd(`IQCOR_Q_PHASE_LO_ADDR, 8'h00);
		wr(7'h50, 8'h55);
		rd(7'h50, 8'h00);
		ioff = 16'sh0100;
		qoff = 16'shFF00;
		set16(`IQCOR_I_OFFSET_LO_ADDR, ioff);
		set16(`IQCOR_Q_OFFSET_LO_ADDR, qoff);
		rd(`IQCOR_Q_OFFSET_HI_ADDR, 8'hFF);
		burst(8);
		ioff = 16'sh7FFF;
		qoff = 16'sh8000;
		set16(`IQCOR_I_OFFSET_LO_ADDR, ioff);
		set16(`IQCOR_Q_OFFSET_LO_ADDR, qoff);
		send(16'sh7000, 16'sh9000, 1'b1);
		send(16'sh8000, 16'sh7FFF, 1'b1);
		idle();
		ioff = 16'sh0000;
		qoff = 16'sh0000;
		set16(`IQCOR_I_OFFSET_LO_ADDR, ioff);
		set16(`IQCOR_Q_OFFSET_LO_ADDR, qoff);
		// Both trim ends, one step and zero, with the channels crossed.
		for (int k = 0; k < 4; k++) begin
			itr = tabl[k];
			qtr = tabl[3 - k];
			set16(`IQCOR_I_PHASE_LO_ADDR, {6'h00, itr});
			set16(`IQCOR_Q_PHASE_LO_ADDR, {6'h00, qtr});
			send(16'sh4000, 16'shC000, 1'b1);
			idle();
		end
		flt = 1'b1;
		wr(`IQCOR_DATAPATH_CONTROL_ADDR, 8'h00);
		rd(`IQCOR_DATAPATH_CONTROL_ADDR, 8'h00);
		// Settled DC through the filter; the edges of the burst are not judged.
		for (int k = 0; k < 24; k++) send(16'sh0400, 16'shFC00, k > 9 && k < 19);
		idle();
		end_sim();
	end
endmodule : iqcor_corrector_tb
